//--- battery_stack_fault_monitor.sv
/*
  Stack fault monitor: cell high/low and balance-low checks, stack sum,
  critical and comparator checks, open-wire evaluation, latched flags,
  fault line, override, balance stop and chain status word.
  Assumes the conversion routine presents results as one-cycle strobes
  and registers are reached over a plain strobe port.
*/
// The address-and-strobe port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
module battery_stack_fault_monitor
  import fault_monitor_pkg::*;
#(
  parameter int FILTER_CYCLES = FILT_CYCLES
) (
  input wire logic clock, // System clock, 40 MHz.
  input wire logic rst, // Asynchronous reset, active high.
  input wire logic [ADDR_W-1:0] addr, // Register index.
  input wire logic [DATA_W-1:0] wdata, // Write data.
  input wire logic wr, // Write strobe.
  input wire logic rd, // Read strobe.
  output logic [DATA_W-1:0] rdata, // Read data, cycle after rd.
  input wire logic cell_valid, // Cell result strobe.
  input wire logic [3:0] cell_idx, // Cell index 0..13.
  input wire logic [RES_W-1:0] cell_result, // Cell result.
  input wire logic sum_done, // End of cell conversion step.
  input wire logic stack_valid, // Stack pin result strobe.
  input wire logic [RES_W-1:0] stack_result, // Stack pin result.
  input wire logic comp_high, // Warning comparator, over level.
  input wire logic comp_low, // Warning comparator, under level.
  input wire logic open_step, // Cell terminal diagnostic step active.
  input wire logic open_valid, // Open drop strobe.
  input wire logic [3:0] open_idx, // Cell index of the drop.
  input wire logic [RES_W-1:0] open_drop, // Drop under pull-down current.
  input wire logic bottom_valid, // Bottom terminal level strobe.
  input wire logic [RES_W-1:0] bottom_level, // Bottom terminal level.
  output logic [CELLS-1:0] pulldown_en, // Per-cell pull-down current enable.
  output logic bottom_pullup_en, // Bottom terminal pull-up enable.
  output logic fault_line, // Fault line, high while any flag is set.
  output logic config_override, // Conversion routine override request.
  output logic balance_stop_all, // Stop balancing on the whole stack.
  output logic [CELLS-1:0] balance_stop_cell, // Stop balancing per cell.
  output logic [15:0] chain_status_word // Status word for the chain link.
);
  logic pair_check_q;
  logic [CELLS-1:0] cell_channel_enable_q;
  logic [CELLS-1:0] cell_balance_low_mask_q;
  logic [19:0] cell_high_th_q;
  logic [19:0] cell_low_th_q;
  logic [19:0] bal_delta_q;
  logic [19:0] stack_sum_high_threshold_q;
  logic [19:0] stack_sum_low_threshold_q;
  logic [19:0] open_th_q;
  logic [19:0] open_large_th_q;
  logic [CELLS-1:0] cell_high_flag_q;
  logic [CELLS-1:0] cell_low_flag_q;
  logic [CELLS-1:0] cell_balance_low_flag_q;
  logic [CELLS:0] cell_input_open_flag_q;
  logic [5:0] stack_flag_q;
  logic [SUM_W-1:0] sum_acc_q;
  logic [SUM_W-1:0] stack_sum_q;
  logic [DATA_W-1:0] rdata_q;
  logic [15:0] status_q;
  logic warn_high;
  logic warn_low;

  // Address decode.
  wire wr_ctrl = wr && addr == REG_CTRL;
  wire wr_en = wr && addr == REG_CELL_EN;
  wire wr_chth = wr && addr == REG_CELL_HIGH_TH;
  wire wr_clth = wr && addr == REG_CELL_LOW_TH;
  wire wr_bd = wr && addr == REG_BAL_DELTA;
  wire wr_bm = wr && addr == REG_BAL_MASK;
  wire wr_shth = wr && addr == REG_SUM_HIGH_TH;
  wire wr_slth = wr && addr == REG_SUM_LOW_TH;
  wire wr_oth = wr && addr == REG_OPEN_TH;
  wire wr_olth = wr && addr == REG_OPEN_LARGE_TH;
  wire [CELLS-1:0] clr_ch = (wr && addr == REG_CELL_HIGH_FLAG) ? wdata[CELLS-1:0] : '0;
  wire [CELLS-1:0] clr_cl = (wr && addr == REG_CELL_LOW_FLAG) ? wdata[CELLS-1:0] : '0;
  wire [CELLS-1:0] clr_bl = (wr && addr == REG_BAL_LOW_FLAG) ? wdata[CELLS-1:0] : '0;
  wire [CELLS:0] clr_op = (wr && addr == REG_OPEN_FLAG) ? wdata[CELLS:0] : '0;
  wire [5:0] clr_sf = (wr && addr == REG_STACK_FLAG) ? wdata[5:0] : '0;

  // Cell checks on the enabled cell that the strobe selects.
  wire [CELLS-1:0] cell_sel = cell_valid ? (CELLS'(1) << cell_idx) & cell_channel_enable_q : '0; // RULE_03
  wire [19:0] cell_res20 = {4'h0, cell_result};
  wire [20:0] bal_low_th = {1'b0, cell_low_th_q} + {1'b0, bal_delta_q}; // RULE_02
  wire cell_hi = cell_res20 > cell_high_th_q;
  wire cell_lo = cell_res20 < cell_low_th_q;
  wire cell_bl = {5'h00, cell_result} < bal_low_th;
  wire [CELLS-1:0] set_ch = cell_hi ? cell_sel : '0; // RULE_03
  wire [CELLS-1:0] set_cl = cell_lo ? cell_sel : '0; // RULE_03
  wire [CELLS-1:0] set_bl = cell_bl ? cell_sel & ~cell_balance_low_mask_q : '0; // RULE_06

  // Stack sum, critical and comparator checks.
  wire [SUM_W-1:0] sum_next = sum_acc_q + {4'h0, cell_result};
  wire cell_any = |cell_sel;
  wire [5:0] set_sf = {
    warn_low, // RULE_15
    warn_high, // RULE_12
    stack_valid && stack_result < CRIT_LOW_TH, // RULE_08
    stack_valid && stack_result > CRIT_HIGH_TH, // RULE_08
    sum_done && sum_acc_q < stack_sum_low_threshold_q, // RULE_13
    sum_done && sum_acc_q > stack_sum_high_threshold_q // RULE_10
  };

  // Open-wire evaluation, only with the pair check deselected.
  wire open_go = open_valid && !pair_check_q; // RULE_16
  wire [CELLS-1:0] open_sel = open_go ? (CELLS'(1) << open_idx) & cell_channel_enable_q : '0; // RULE_19
  wire open_hit = {4'h0, open_drop} > open_th_q; // RULE_20
  wire open_large = open_idx[0] && {4'h0, open_drop} > open_large_th_q; // RULE_18
  wire [CELLS-1:0] open_cells = open_hit ? open_sel | (open_large ? open_sel >> 1 : '0) : '0; // RULE_17
  wire bottom_open = bottom_valid && !pair_check_q && {4'h0, bottom_level} > open_th_q; // RULE_21
  wire [CELLS:0] set_op = {bottom_open, open_cells}; // RULE_22

  // Diagnostic currents follow the step and the strategy bit.
  assign pulldown_en = (open_step && !pair_check_q) ? cell_channel_enable_q : '0; // RULE_16
  assign bottom_pullup_en = open_step && !pair_check_q; // RULE_21

  // Warning comparator filters; no control bit reaches them.
  persist_filter #(.CYCLES(FILTER_CYCLES)) u_filt_high ( // RULE_09
    .clock(clock),
    .rst(rst),
    .level_in(comp_high),
    .level_out(warn_high)
  );
  persist_filter #(.CYCLES(FILTER_CYCLES)) u_filt_low ( // RULE_09
    .clock(clock),
    .rst(rst),
    .level_in(comp_low),
    .level_out(warn_low)
  );

  // Outputs derived from latched flags.
  wire routine_fault = |{cell_high_flag_q, cell_low_flag_q, cell_balance_low_flag_q,
    cell_input_open_flag_q, stack_flag_q[3:0]}; // RULE_11
  assign config_override = routine_fault; // RULE_22
  assign fault_line = routine_fault || |stack_flag_q[5:4]; // RULE_01
  assign balance_stop_all = |cell_low_flag_q || stack_flag_q[SF_SUM_LOW]
    || stack_flag_q[SF_CRIT_LOW]; // RULE_04 RULE_14
  assign balance_stop_cell = cell_balance_low_flag_q; // RULE_05
  assign chain_status_word = status_q;
  assign rdata = rdata_q;

  // Read multiplexer; unmapped indices read zero.
  logic [DATA_W-1:0] rmux;
  always_comb begin
    rmux = '0;
    case (addr)
      REG_CTRL: rmux[CTRL_PAIR_CHECK_BIT] = pair_check_q;
      REG_CELL_EN: rmux[CELLS-1:0] = cell_channel_enable_q;
      REG_CELL_HIGH_TH: rmux = cell_high_th_q;
      REG_CELL_LOW_TH: rmux = cell_low_th_q;
      REG_BAL_DELTA: rmux = bal_delta_q;
      REG_BAL_MASK: rmux[CELLS-1:0] = cell_balance_low_mask_q;
      REG_SUM_HIGH_TH: rmux = stack_sum_high_threshold_q;
      REG_SUM_LOW_TH: rmux = stack_sum_low_threshold_q;
      REG_OPEN_TH: rmux = open_th_q;
      REG_OPEN_LARGE_TH: rmux = open_large_th_q;
      REG_CELL_HIGH_FLAG: rmux[CELLS-1:0] = cell_high_flag_q;
      REG_CELL_LOW_FLAG: rmux[CELLS-1:0] = cell_low_flag_q;
      REG_BAL_LOW_FLAG: rmux[CELLS-1:0] = cell_balance_low_flag_q;
      REG_OPEN_FLAG: rmux[CELLS:0] = cell_input_open_flag_q;
      REG_STACK_FLAG: rmux[5:0] = stack_flag_q;
      REG_STACK_SUM: rmux = stack_sum_q;
      default: rmux = '0;
    endcase
  end

  // Configuration registers written by software.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pair_check_q <= 1'b0;
      cell_channel_enable_q <= '0;
      cell_balance_low_mask_q <= '0;
      cell_high_th_q <= RST_CELL_HIGH_TH;
      cell_low_th_q <= RST_CELL_LOW_TH;
      bal_delta_q <= '0;
      stack_sum_high_threshold_q <= RST_SUM_HIGH_TH;
      stack_sum_low_threshold_q <= RST_SUM_LOW_TH;
      open_th_q <= RST_OPEN_TH;
      open_large_th_q <= RST_OPEN_LARGE_TH;
    end else begin
      if (wr_ctrl) pair_check_q <= wdata[CTRL_PAIR_CHECK_BIT];
      if (wr_en) cell_channel_enable_q <= wdata[CELLS-1:0];
      if (wr_bm) cell_balance_low_mask_q <= wdata[CELLS-1:0];
      if (wr_chth) cell_high_th_q <= wdata;
      if (wr_clth) cell_low_th_q <= wdata;
      if (wr_bd) bal_delta_q <= wdata;
      if (wr_shth) stack_sum_high_threshold_q <= wdata;
      if (wr_slth) stack_sum_low_threshold_q <= wdata;
      if (wr_oth) open_th_q <= wdata;
      if (wr_olth) open_large_th_q <= wdata;
    end
  end

  // Sticky flags: a set in the clearing cycle wins over the clear.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cell_high_flag_q <= '0;
      cell_low_flag_q <= '0;
      cell_balance_low_flag_q <= '0;
      cell_input_open_flag_q <= '0;
      stack_flag_q <= '0;
    end else begin
      cell_high_flag_q <= (cell_high_flag_q & ~clr_ch) | set_ch; // RULE_23
      cell_low_flag_q <= (cell_low_flag_q & ~clr_cl) | set_cl; // RULE_23
      cell_balance_low_flag_q <= (cell_balance_low_flag_q & ~clr_bl) | set_bl; // RULE_23
      cell_input_open_flag_q <= (cell_input_open_flag_q & ~clr_op) | set_op; // RULE_23
      stack_flag_q <= (stack_flag_q & ~clr_sf) | set_sf; // RULE_23
    end
  end

  // Stack sum accumulates enabled cells and restarts at each step end.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sum_acc_q <= '0;
      stack_sum_q <= '0;
    end else if (sum_done) begin
      stack_sum_q <= sum_acc_q; // RULE_07
      sum_acc_q <= '0;
    end else if (cell_any) begin
      sum_acc_q <= sum_next; // RULE_07
    end
  end

  // Read data and the registered chain status word.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rdata_q <= '0;
      status_q <= '0;
    end else begin
      rdata_q <= rd ? rmux : '0;
      status_q <= {5'h00, fault_line, stack_flag_q, |cell_input_open_flag_q,
        |cell_balance_low_flag_q, |cell_low_flag_q, |cell_high_flag_q}; // RULE_01
    end
  end

  // Checks that tie outputs to their causes.
  AST_CELL_HIGH: assert property (@(posedge clock) disable iff (rst) // RULE_03
    (cell_valid && cell_idx < 4'hE && cell_channel_enable_q[cell_idx]
     && cell_res20 > cell_high_th_q) |=> (cell_high_flag_q[$past(cell_idx)] && config_override))
    else $error("Cell high event not latched.");
  AST_CELL_IGNORED: assert property (@(posedge clock) disable iff (rst) // RULE_03
    (cell_valid && cell_idx < 4'hE && !cell_channel_enable_q[cell_idx]
     && !cell_low_flag_q[cell_idx] && clr_cl == '0) |=> !cell_low_flag_q[$past(cell_idx)])
    else $error("Disabled cell set a flag.");
  AST_STOP_ALL: assert property (@(posedge clock) disable iff (rst) // RULE_04
    (cell_valid && cell_idx < 4'hE && cell_channel_enable_q[cell_idx]
     && cell_res20 < cell_low_th_q) |=> balance_stop_all && fault_line && config_override)
    else $error("Cell low did not stop all balancing.");
  AST_BAL_MASK: assert property (@(posedge clock) disable iff (rst) // RULE_06
    (cell_valid && cell_idx < 4'hE && cell_balance_low_mask_q[cell_idx]
     && !cell_balance_low_flag_q[cell_idx] && clr_bl == '0)
    |=> !cell_balance_low_flag_q[$past(cell_idx)])
    else $error("Masked balance low set a flag.");
  AST_BAL_ONE: assert property (@(posedge clock) disable iff (rst) // RULE_05
    (cell_balance_low_flag_q == '0 && set_bl != '0 && cell_low_flag_q == '0 && set_cl == '0
     && stack_flag_q[3] == 1'b0 && stack_flag_q[1] == 1'b0 && set_sf[3:0] == '0)
    |=> balance_stop_cell == $past(set_bl) && !balance_stop_all)
    else $error("Balance low stopped other cells.");
  AST_SUM_HIGH: assert property (@(posedge clock) disable iff (rst) // RULE_10
    (sum_done && sum_acc_q > stack_sum_high_threshold_q) |=> stack_flag_q[SF_SUM_HIGH]
    ##0 stack_sum_q == $past(sum_acc_q))
    else $error("Stack sum high not latched.");
  AST_CRIT_LOW: assert property (@(posedge clock) disable iff (rst) // RULE_14
    (stack_valid && stack_result < CRIT_LOW_TH) |=> stack_flag_q[SF_CRIT_LOW]
    && balance_stop_all && config_override)
    else $error("Critical low not handled.");
  AST_WARN_ONLY: assert property (@(posedge clock) disable iff (rst) // RULE_12
    (stack_flag_q[5:4] != 2'b00 && !routine_fault) |-> fault_line && !config_override)
    else $error("Warning touched the routine.");
  AST_FILTER: assert property (@(posedge clock) disable iff (rst) // RULE_10
    (!comp_high ##1 comp_high) |=> !warn_high)
    else $error("Comparator qualified too early.");
  AST_OPEN_LARGE: assert property (@(posedge clock) disable iff (rst) // RULE_18
    (open_go && open_idx < 4'hE && cell_channel_enable_q[open_idx] && open_large && open_hit)
    |=> cell_input_open_flag_q[$past(open_idx)]
    && cell_input_open_flag_q[$past(open_idx) - 4'h1])
    else $error("Large degradation missed the odd cell.");
  AST_PAIR_SELECT: assert property (@(posedge clock) disable iff (rst) // RULE_16
    pair_check_q |-> pulldown_en == '0 && !bottom_pullup_en)
    else $error("Pull-down active with pair check.");
  AST_HOLD: assert property (@(posedge clock) disable iff (rst) // RULE_23
    (stack_flag_q[SF_CRIT_HIGH] && !clr_sf[SF_CRIT_HIGH]) |=> stack_flag_q[SF_CRIT_HIGH])
    else $error("Flag dropped without a clear.");
endmodule : battery_stack_fault_monitor

//--- fault_monitor_pkg.sv
/*
  Constants shared by the stack fault monitor: register indices, flag
  positions, fixed thresholds, widths and timing counts.
  Assumes a 40 MHz clock and 20-bit register data.
*/
// Notes on behaviour
// [RULE_01] Faults shown on word, line and registers.
// [RULE_02] Balance low threshold is low plus increment.
// [RULE_03] Enabled cell high/low latches flag, fault, override.
// [RULE_04] Cell low event stops balancing everywhere.
// [RULE_05] Balance-low event stops only that cell.
// [RULE_06] Masked balance-low sets nothing at all.
// [RULE_07] Sum enabled cells in twenty bits, compare.
// [RULE_08] Stack pin result meets fixed critical thresholds.
// [RULE_09] Warning comparator always on, never disabled.
// [RULE_10] Stack high has three flags; comparator filtered.
// [RULE_11] Routine stack high latches, faults, overrides.
// [RULE_12] Comparator high latches warning, faults only.
// [RULE_13] Stack low has three flags; comparator filtered.
// [RULE_14] Routine stack low also stops all balancing.
// [RULE_15] Comparator low latches warning, faults only.
// [RULE_16] Select bit zero applies pull-down currents.
// [RULE_17] Odd cell degradation sets own flag only.
// [RULE_18] Large even degradation also flags odd below.
// [RULE_19] Open check only on enabled cells.
// [RULE_20] Drop above threshold declares input open.
// [RULE_21] Bottom terminal open above threshold, pull-up.
// [RULE_22] Open detection latches flag, faults, overrides.
// [RULE_23] Flags hold until software clears them.
package fault_monitor_pkg;
  localparam int DATA_W = 20;
  localparam int ADDR_W = 5;
  localparam int CELLS = 14;
  localparam int RES_W = 16;
  localparam int SUM_W = 20;
  // Register indices.
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_CELL_EN = 5'h01;
  localparam logic [4:0] REG_CELL_HIGH_TH = 5'h02;
  localparam logic [4:0] REG_CELL_LOW_TH = 5'h03;
  localparam logic [4:0] REG_BAL_DELTA = 5'h04;
  localparam logic [4:0] REG_BAL_MASK = 5'h05;
  localparam logic [4:0] REG_SUM_HIGH_TH = 5'h06;
  localparam logic [4:0] REG_SUM_LOW_TH = 5'h07;
  localparam logic [4:0] REG_OPEN_TH = 5'h08;
  localparam logic [4:0] REG_OPEN_LARGE_TH = 5'h09;
  localparam logic [4:0] REG_CELL_HIGH_FLAG = 5'h0A;
  localparam logic [4:0] REG_CELL_LOW_FLAG = 5'h0B;
  localparam logic [4:0] REG_BAL_LOW_FLAG = 5'h0C;
  localparam logic [4:0] REG_OPEN_FLAG = 5'h0D;
  localparam logic [4:0] REG_STACK_FLAG = 5'h0E;
  localparam logic [4:0] REG_STACK_SUM = 5'h0F;
  // Field positions.
  localparam int CTRL_PAIR_CHECK_BIT = 0;
  localparam int OPEN_BOTTOM_BIT = 14;
  localparam int SF_SUM_HIGH = 0;
  localparam int SF_SUM_LOW = 1;
  localparam int SF_CRIT_HIGH = 2;
  localparam int SF_CRIT_LOW = 3;
  localparam int SF_WARN_HIGH = 4;
  localparam int SF_WARN_LOW = 5;
  // Reset values.
  localparam logic [19:0] RST_CELL_HIGH_TH = 20'h0FFFF;
  localparam logic [19:0] RST_CELL_LOW_TH = 20'h00000;
  localparam logic [19:0] RST_SUM_HIGH_TH = 20'hFFFFF;
  localparam logic [19:0] RST_SUM_LOW_TH = 20'h00000;
  localparam logic [19:0] RST_OPEN_TH = 20'h0FFFF;
  localparam logic [19:0] RST_OPEN_LARGE_TH = 20'h0FFFF;
  // Fixed critical thresholds on the stack pin result.
  localparam logic [15:0] CRIT_HIGH_TH = 16'hF000;
  localparam logic [15:0] CRIT_LOW_TH = 16'h0800;
  // Comparator filter time and its cycle count at 40 MHz.
  localparam int CLK_PERIOD_PS = 25000;
  localparam int FILT_TIME_NS = 10000;
  localparam int FILT_CYCLES = (FILT_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
endpackage : fault_monitor_pkg

//--- persist_filter.sv
/*
  Persistence filter for one comparator level.
  Assumes the raw level is synchronous to clock.
*/
`timescale 1ns/10ps
module persist_filter #(
  parameter int CYCLES = 1
) (
  input wire logic clock, // System clock.
  input wire logic rst, // Asynchronous reset, active high.
  input wire logic level_in, // Raw comparator level.
  output logic level_out // High once the level has lasted past the filter time.
);
  localparam int CW = $clog2(CYCLES + 2);
  localparam logic [CW-1:0] LIMIT = CW'(CYCLES);
  logic [CW-1:0] count_q;
  logic [CW-1:0] count_d;
  logic out_q;

  // Count while the level holds; any gap restarts the count.
  assign count_d = !level_in ? '0 : (count_q > LIMIT) ? count_q : count_q + CW'(1);
  assign level_out = out_q;

  // Output qualifies only after strictly more than the filter count.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      count_q <= '0;
      out_q <= 1'b0;
    end else begin
      count_q <= count_d;
      out_q <= level_in && (count_q >= LIMIT);
    end
  end
endmodule : persist_filter

//--- routine_model.sv
/*
  Stand-in for the conversion routine: hands cell, sum, stack, open and
  bottom results to the monitor as one-cycle strobes.
  Assumes its task is entered from a process on the same clock.
*/
`timescale 1ns/10ps
module routine_model
  import fault_monitor_pkg::*;
(
  input wire logic clock, // System clock.
  output logic [4:0] stb, // Strobes: cell, sum end, stack, open, bottom.
  output logic [3:0] idx, // Cell index beside the strobe.
  output logic [RES_W-1:0] res // Result beside the strobe.
);
  // Nothing is offered before the first request.
  initial begin
    stb = '0;
    idx = 4'h0;
    res = '0;
  end

  // One strobe at a time, so a sum end never meets a cell result; data flip afterwards.
  task automatic put(input int kind, input logic [3:0] i, input logic [RES_W-1:0] v);
    @(posedge clock);
    idx <= i;
    res <= v;
    stb <= 5'h01 << kind;
    @(posedge clock);
    stb <= 5'h00;
    idx <= ~i;
    res <= ~v;
  endtask : put
endmodule : routine_model

//--- test_battery_stack_fault_monitor.sv
/*
  Self-checking bench for the stack fault monitor, random cell results.
  Assumes the routine model and the fault monitor package.
*/
`timescale 1ns/10ps
module test_battery_stack_fault_monitor
  import fault_monitor_pkg::*;
;
  localparam int FILT = 3;
  localparam logic [15:0] CRIT_V [4] = '{CRIT_HIGH_TH, CRIT_HIGH_TH + 16'h0001,
                                         CRIT_LOW_TH, CRIT_LOW_TH - 16'h0001};
  localparam logic [19:0] CRIT_E [4] = '{20'h00000, 20'h00004, 20'h00000, 20'h00008};
  logic clock = 1'h0;
  logic rst = 1'h1;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wdata = '0;
  logic wr = 1'h0, rd = 1'h0, comp_high = 1'h0, comp_low = 1'h0, open_step = 1'h0;
  logic [DATA_W-1:0] rdata, got, exp_sum;
  logic [4:0] stb;
  logic [3:0] idx;
  logic [RES_W-1:0] res, rv;
  logic [CELLS-1:0] pulldown_en, balance_stop_cell;
  logic bottom_pullup_en, fault_line, config_override, balance_stop_all;
  logic [15:0] chain_status_word;
  int error_cnt = 0, n_tests = 0, seed = 81878;

  // Clock at 40 MHz.
  always #12.5 clock = ~clock;

  routine_model conv (.clock(clock), .stb(stb), .idx(idx), .res(res));

  battery_stack_fault_monitor #(.FILTER_CYCLES(FILT)) uut (
    .clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .cell_valid(stb[0]), .cell_idx(idx), .cell_result(res), .sum_done(stb[1]),
    .stack_valid(stb[2]), .stack_result(res), .comp_high(comp_high), .comp_low(comp_low),
    .open_step(open_step), .open_valid(stb[3]), .open_idx(idx), .open_drop(res),
    .bottom_valid(stb[4]), .bottom_level(res), .pulldown_en(pulldown_en),
    .bottom_pullup_en(bottom_pullup_en), .fault_line(fault_line),
    .config_override(config_override), .balance_stop_all(balance_stop_all),
    .balance_stop_cell(balance_stop_cell), .chain_status_word(chain_status_word));

  // Compares one value and counts the outcome.
  task automatic chk(input string what, input logic [19:0] e, input logic [19:0] g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", what, e, g);
    end
  endtask : chk

  // One-cycle register write.
  task automatic wreg(input logic [4:0] a, input logic [19:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'h1;
    @(posedge clock);
    wr <= 1'h0;
  endtask : wreg

  // One-cycle register read; data are taken in the following cycle only.
  task automatic rreg(input logic [4:0] a);
    @(posedge clock);
    addr <= a;
    rd <= 1'h1;
    @(posedge clock);
    rd <= 1'h0;
    #1 got = rdata;
  endtask : rreg

  // Expected sum flags: bit 0 above the high threshold, bit 1 below the low one.
  function automatic logic [19:0] sum_flags(input logic [19:0] s, input logic [19:0] th);
    return {18'h00000, s < th, s > th};
  endfunction : sum_flags

  // Prints the counts and the verdict, then stops.
  task automatic end_sim();
    $display("checks %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_sim

  // Cuts a hang short.
  initial begin
    repeat (6000) @(posedge clock);
    error_cnt++;
    end_sim();
  end

  // Main sequence.
  initial begin
    repeat (20) @(posedge clock);
    rst <= 1'h0;
    rreg(REG_SUM_HIGH_TH);
    chk("sum high reset", RST_SUM_HIGH_TH, got);
    rreg(5'h1F);
    chk("unmapped read", 20'h00000, got);
    // Random cell rounds: stack sum and its two flags.
    wreg(REG_CELL_EN, 20'h03FFF);
    wreg(REG_SUM_HIGH_TH, 20'h1C000);
    wreg(REG_SUM_LOW_TH, 20'h1C000);
    for (int r = 0; r < 3; r++) begin
      exp_sum = '0;
      for (int c = 0; c < CELLS; c++) begin
        rv = 16'($random(seed)) & 16'h3FFF;
        conv.put(0, 4'(c), rv);
        exp_sum += 20'(rv);
      end
      conv.put(1, 4'h0, 16'h0000);
      #1 chk("sum low stop", 20'(exp_sum < 20'h1C000), 20'(balance_stop_all));
      chk("sum override", 20'(exp_sum != 20'h1C000), 20'(config_override));
      rreg(REG_STACK_SUM);
      chk("stack sum", exp_sum, got);
      rreg(REG_STACK_FLAG);
      chk("sum flags", sum_flags(exp_sum, 20'h1C000), got);
      wreg(REG_STACK_FLAG, 20'h0003F);
    end
    // Critical thresholds on both sides of each boundary.
    for (int k = 0; k < 4; k++) begin
      conv.put(2, 4'h0, CRIT_V[k]);
      rreg(REG_STACK_FLAG);
      chk("critical flags", CRIT_E[k], got);
      wreg(REG_STACK_FLAG, 20'h0003F);
    end
    // Comparator levels: one just at the filter time, one well beyond it.
    for (int k = 0; k < 2; k++) begin
      for (int len = FILT; len <= FILT + 8; len += 8) begin
        @(posedge clock);
        comp_high <= (k == 0);
        comp_low <= (k == 1);
        repeat (len) @(posedge clock);
        comp_high <= 1'h0;
        comp_low <= 1'h0;
        #1 chk("warn fault", 20'(len > FILT), 20'(fault_line));
        chk("warn override", 20'h00000, 20'(config_override));
        repeat (4) @(posedge clock);
        rreg(REG_STACK_FLAG);
        chk("warn flags", (len > FILT) ? 20'h1 << (SF_WARN_HIGH + k) : 20'h0, got);
        wreg(REG_STACK_FLAG, 20'h0003F);
      end
    end
    // Cell high, low and balance-low, cell 3 disabled and cell 6 masked.
    wreg(REG_CELL_EN, 20'h03FF7);
    wreg(REG_CELL_HIGH_TH, 20'h0C000);
    wreg(REG_CELL_LOW_TH, 20'h01000);
    wreg(REG_BAL_DELTA, 20'h00800);
    wreg(REG_BAL_MASK, 20'h00040);
    conv.put(0, 4'h2, 16'hC001);
    #1 chk("cell fault", 20'h00001, 20'(fault_line));
    chk("cell override", 20'h00001, 20'(config_override));
    @(posedge clock);
    #1 chk("status word", 20'h00401, 20'(chain_status_word & 16'h0401));
    conv.put(0, 4'h3, 16'hFFFF);
    conv.put(0, 4'h5, 16'h17FF);
    #1 chk("one cell stop", 20'h00020, 20'(balance_stop_cell));
    chk("no stack stop", 20'h00000, 20'(balance_stop_all));
    conv.put(0, 4'h6, 16'h1000);
    conv.put(0, 4'h8, 16'h1800);
    conv.put(0, 4'h7, 16'h0FFF);
    #1 chk("stack stop", 20'h00001, 20'(balance_stop_all));
    rreg(REG_CELL_HIGH_FLAG);
    chk("high flags", 20'h00004, got);
    rreg(REG_CELL_HIGH_FLAG);
    chk("high flags held", 20'h00004, got);
    rreg(REG_CELL_LOW_FLAG);
    chk("low flags", 20'h00080, got);
    rreg(REG_BAL_LOW_FLAG);
    chk("balance low flags", 20'h000A0, got);
    for (int a = 10; a < 14; a++) begin
      wreg(5'(a), 20'hFFFFF);
    end
    #1 chk("fault cleared", 20'h00000, 20'(fault_line));
    // Open-wire step with pull-down currents, boundaries and a disabled cell.
    wreg(REG_OPEN_TH, 20'h00100);
    wreg(REG_OPEN_LARGE_TH, 20'h00400);
    @(posedge clock);
    open_step <= 1'h1;
    @(posedge clock);
    #1 chk("pull-downs", 20'h03FF7, 20'(pulldown_en));
    chk("pull-up", 20'h00001, 20'(bottom_pullup_en));
    conv.put(3, 4'h4, 16'h0200);
    conv.put(3, 4'h9, 16'h0500);
    conv.put(3, 4'hA, 16'h0500);
    conv.put(3, 4'h3, 16'h0500);
    conv.put(3, 4'h0, 16'h0100);
    conv.put(4, 4'h0, 16'h0101);
    #1 chk("open override", 20'h00001, 20'(config_override));
    rreg(REG_OPEN_FLAG);
    chk("open flags", 20'h04710, got);
    wreg(REG_CTRL, 20'h00001);
    open_step <= 1'h0;
    #1 chk("pull-downs off", 20'h00000, 20'(pulldown_en));
    end_sim();
  end
endmodule : test_battery_stack_fault_monitor
